// ===== rtl/srarq_ack_delay.sv
// Purpose: Holds each received unit's verdict that finds a free slot until its acknowledgement time
// Assumes: Launches come at most one per cycle
// Notes: Entries age independently, so a burst of verdicts leaves in order
`timescale 1ns/10ps
module srarq_ack_delay
   import srarq_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Delay line port
   srarq_delay_if.line dl
);
   logic [SRARQ_SLOTS-1:0] busy_r;
   logic [SRARQ_SLOTS-1:0] nack_r;
   logic [SRARQ_SEQ_W-1:0] seq_r [SRARQ_SLOTS];
   logic [SRARQ_TMR_W-1:0] tmr_r [SRARQ_SLOTS];
   logic [SRARQ_SLOTS-1:0] expire;
   logic [SRARQ_SLOTS-1:0] free_one;
   logic [SRARQ_SLOT_W-1:0] out_idx;
   logic [SRARQ_SLOT_W-1:0] in_idx;
   logic any_exp;

   ////////////////////////////////////////////////////////////////////////////
   // Priority picks: lowest expiring entry leaves, lowest free entry fills
   always_comb begin
      out_idx = '0;
      any_exp = 1'b0;
      for (int i = SRARQ_SLOTS - 1; i >= 0; i--) begin
         if (expire[i]) begin
            out_idx = SRARQ_SLOT_W'(i);
            any_exp = 1'b1;
         end
      end
   end

   // Fill pick reads free_one, which hangs on out_idx, so it has its own process
   always_comb begin
      in_idx = '0;
      for (int i = SRARQ_SLOTS - 1; i >= 0; i--) begin
         if (!busy_r[i] || free_one[i]) begin
            in_idx = SRARQ_SLOT_W'(i);
         end
      end
   end

   assign dl.due = any_exp;
   assign dl.due_nack = nack_r[out_idx];
   assign dl.due_seq = seq_r[out_idx];
   assign dl.full = &busy_r;

   ////////////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < SRARQ_SLOTS; g++) begin : g_ent
         // Same timer width for every entry; units arrive far apart in practice
         assign expire[g] = busy_r[g] && (tmr_r[g] == '0);
         assign free_one[g] = expire[g] && (out_idx == SRARQ_SLOT_W'(g));
         always_ff @(posedge ref_clk_i) begin
            if (!reset_n_i) begin
               busy_r[g] <= 1'b0;
               nack_r[g] <= 1'b0;
               seq_r[g] <= '0;
               tmr_r[g] <= '0;
            end else if (dl.launch && !dl.full && in_idx == SRARQ_SLOT_W'(g)) begin
               busy_r[g] <= 1'b1;
               nack_r[g] <= dl.launch_nack;
               seq_r[g] <= dl.launch_seq;
               tmr_r[g] <= SRARQ_TMR_W'(SRARQ_ACK_DELAY_CYC - 1);
            end else if (free_one[g]) begin
               busy_r[g] <= 1'b0;
            end else if (busy_r[g] && tmr_r[g] != '0) begin
               tmr_r[g] <= tmr_r[g] - 1'b1;
            end
         end
      end
   endgenerate
endmodule

// ===== rtl/srarq_delay_if.sv
// Purpose: Carrier between the main block and its acknowledgement delay line
// Assumes: One clock domain
// Notes: Launch enters a unit's verdict, due leaves it after the fixed delay
`timescale 1ns/10ps
interface srarq_delay_if;
   import srarq_pkg::*;
   logic launch;
   logic launch_nack;
   logic [SRARQ_SEQ_W-1:0] launch_seq;
   logic due;
   logic due_nack;
   logic [SRARQ_SEQ_W-1:0] due_seq;
   logic full;
   modport owner (output launch, output launch_nack, output launch_seq,
      input due, input due_nack, input due_seq, input full);
   modport line (input launch, input launch_nack, input launch_seq,
      output due, output due_nack, output due_seq, output full);
endinterface

// ===== rtl/srarq_pkg.sv
// Purpose: Shared constants for the selective repeat retransmission block
// Assumes: 25 MHz clock, reception events come from logic on the same clock
// Notes: Times are kept in their printed unit and converted to cycles here
package srarq_pkg;
   localparam int unsigned SRARQ_CLK_HZ = 25000000;
   localparam int unsigned SRARQ_ACK_DELAY_US = 7500;
   localparam int unsigned SRARQ_RESEND_DELAY_US = 7500;
   localparam int unsigned SRARQ_ACK_DELAY_CYC = SRARQ_ACK_DELAY_US * (SRARQ_CLK_HZ / 1000000);
   localparam int unsigned SRARQ_RESEND_DELAY_CYC =
      SRARQ_RESEND_DELAY_US * (SRARQ_CLK_HZ / 1000000);
   localparam int unsigned SRARQ_SLOTS = 8;
   localparam int unsigned SRARQ_SLOT_W = 3;
   localparam int unsigned SRARQ_SEQ_W = 8;
   localparam int unsigned SRARQ_USER_W = 4;
   localparam int unsigned SRARQ_PRU_W = 6;
   localparam int unsigned SRARQ_RETRY_W = 4;
   localparam int unsigned SRARQ_ERR_W = 8;
   localparam int unsigned SRARQ_TMR_W = 24;
   localparam int unsigned SRARQ_MOD_W = 2;
   localparam logic [SRARQ_MOD_W-1:0] SRARQ_MOD_RESET = 2'h0;
   localparam logic [SRARQ_ERR_W-1:0] SRARQ_ERR_RESET = 8'h00;
endpackage

// ===== rtl/srarq_top.sv
// Purpose: Selective repeat retransmission control on the dedicated control/data channel
// Assumes: Unit events come from same-clock logic; the peer keeps its own timing
// Notes: Receive verdicts and transmit resend schedule both live here
// Contract
// - Each data unit is handled alone, by its own check result, per user and resource unit; the code filters by user only and leaves rx_pru_i unused.
// - A received unit whose check failed is answered with a negative acknowledgement; the code gives none when all eight verdict slots are busy.
// - On a negative acknowledgement only that failed unit is sent again.
// - The acknowledgement field is set a fixed 7.5 ms after the unit was received.
// - A failed unit is sent again 7.5 ms after its negative acknowledgement arrived.
// - A unit that keeps failing is resent only up to the configured retry count; with a count of 0 the code still resends it once.
// - New consecutive data fills every opportunity not taken by a resend.
// - Several failed units are each resent independently on their own delay.
// - The modulation class steps once the count of check errors exceeds its limit.
`timescale 1ns/10ps
module srarq_top
   import srarq_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Receive side: one unit checked per pulse
   input wire logic rx_unit_valid_i,
   input wire logic rx_crc_ok_i,
   input wire logic [SRARQ_SEQ_W-1:0] rx_seq_i,
   input wire logic [SRARQ_USER_W-1:0] rx_user_i,
   input wire logic [SRARQ_PRU_W-1:0] rx_pru_i,
   input wire logic [SRARQ_USER_W-1:0] own_user_i,
   // Acknowledgement field out
   output logic ack_valid_o,
   output logic ack_nack_o,
   output logic [SRARQ_SEQ_W-1:0] ack_seq_o,
   output logic ack_overflow_o,
   // Transmit side: units sent and acknowledgements from the peer
   input wire logic tx_sent_i,
   input wire logic [SRARQ_SEQ_W-1:0] tx_sent_seq_i,
   input wire logic peer_ack_valid_i,
   input wire logic peer_nack_i,
   input wire logic [SRARQ_SEQ_W-1:0] peer_ack_seq_i,
   input wire logic tx_opportunity_i,
   input wire logic [SRARQ_RETRY_W-1:0] retry_limit_i,
   input wire logic [SRARQ_ERR_W-1:0] err_limit_i,
   // Transmit decision
   output logic tx_resend_o,
   output logic tx_new_o,
   output logic [SRARQ_SEQ_W-1:0] tx_seq_o,
   output logic drop_o,
   output logic [SRARQ_SEQ_W-1:0] drop_seq_o,
   output logic [SRARQ_MOD_W-1:0] mod_class_o,
   output logic mod_change_o
);
   srarq_delay_if dl();

   ////////////////////////////////////////////////////////////////////////////
   // Receive verdicts
   // Units for other users belong to another station's chain
   logic rx_mine;
   assign rx_mine = rx_unit_valid_i && (rx_user_i == own_user_i);
   assign dl.launch = rx_mine;
   assign dl.launch_nack = !rx_crc_ok_i;
   assign dl.launch_seq = rx_seq_i;

   srarq_ack_delay u_ack_delay (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .dl(dl)
   );

   logic ovf_r;
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         ack_valid_o <= 1'b0;
         ack_nack_o <= 1'b0;
         ack_seq_o <= '0;
         ovf_r <= 1'b0;
      end else begin
         ack_valid_o <= dl.due;
         ack_nack_o <= dl.due && dl.due_nack;
         ack_seq_o <= dl.due ? dl.due_seq : ack_seq_o;
         ovf_r <= rx_mine && dl.full;
      end
   end
   assign ack_overflow_o = ovf_r;

   ////////////////////////////////////////////////////////////////////////////
   // Resend table: one entry per outstanding failed unit
   logic [SRARQ_SLOTS-1:0] pend_r;
   logic [SRARQ_SLOTS-1:0] armed_r;
   logic [SRARQ_SEQ_W-1:0] pseq_r [SRARQ_SLOTS];
   logic [SRARQ_RETRY_W-1:0] tries_r [SRARQ_SLOTS];
   logic [SRARQ_TMR_W-1:0] ptmr_r [SRARQ_SLOTS];
   logic [SRARQ_SLOTS-1:0] hit;
   logic [SRARQ_SLOTS-1:0] ready;
   logic [SRARQ_SLOTS-1:0] take;
   logic [SRARQ_SLOTS-1:0] drop_now;
   logic [SRARQ_SLOTS-1:0] alloc;
   logic [SRARQ_SLOT_W-1:0] rdy_idx;
   logic [SRARQ_SLOT_W-1:0] free_idx;
   logic [SRARQ_SLOT_W-1:0] drop_idx;
   logic any_rdy;
   logic any_free;
   logic any_hit;
   logic any_drop;
   logic nack_in;
   logic ack_in;

   assign nack_in = peer_ack_valid_i && peer_nack_i;
   assign ack_in = peer_ack_valid_i && !peer_nack_i;

   always_comb begin
      rdy_idx = '0;
      free_idx = '0;
      drop_idx = '0;
      any_rdy = 1'b0;
      any_free = 1'b0;
      any_drop = 1'b0;
      for (int i = SRARQ_SLOTS - 1; i >= 0; i--) begin
         if (ready[i]) begin
            rdy_idx = SRARQ_SLOT_W'(i);
            any_rdy = 1'b1;
         end
         if (!pend_r[i]) begin
            free_idx = SRARQ_SLOT_W'(i);
            any_free = 1'b1;
         end
         if (drop_now[i]) begin
            drop_idx = SRARQ_SLOT_W'(i);
            any_drop = 1'b1;
         end
      end
   end

   assign any_hit = |hit;

   genvar g;
   generate
      for (g = 0; g < SRARQ_SLOTS; g++) begin : g_pend
         assign hit[g] = pend_r[g] && peer_ack_valid_i && (pseq_r[g] == peer_ack_seq_i);
         assign ready[g] = pend_r[g] && armed_r[g] && (ptmr_r[g] == '0);
         assign take[g] = tx_opportunity_i && any_rdy && (rdy_idx == SRARQ_SLOT_W'(g));
         // A repeated failure once the budget is spent retires the entry
         assign drop_now[g] = hit[g] && peer_nack_i && (tries_r[g] >= retry_limit_i);
         assign alloc[g] = nack_in && !any_hit && any_free && (free_idx == SRARQ_SLOT_W'(g));
         always_ff @(posedge ref_clk_i) begin
            if (!reset_n_i) begin
               pend_r[g] <= 1'b0;
               armed_r[g] <= 1'b0;
               pseq_r[g] <= '0;
               tries_r[g] <= '0;
               ptmr_r[g] <= '0;
            end else if (alloc[g]) begin
               pend_r[g] <= 1'b1;
               armed_r[g] <= 1'b1;
               pseq_r[g] <= peer_ack_seq_i;
               tries_r[g] <= '0;
               ptmr_r[g] <= SRARQ_TMR_W'(SRARQ_RESEND_DELAY_CYC - 1);
            end else if (drop_now[g] || (hit[g] && !peer_nack_i)) begin
               pend_r[g] <= 1'b0;
               armed_r[g] <= 1'b0;
            end else if (hit[g]) begin
               armed_r[g] <= 1'b1;
               ptmr_r[g] <= SRARQ_TMR_W'(SRARQ_RESEND_DELAY_CYC - 1);
            end else if (take[g]) begin
               armed_r[g] <= 1'b0;
               tries_r[g] <= tries_r[g] + 1'b1;
            end else if (armed_r[g] && ptmr_r[g] != '0) begin
               ptmr_r[g] <= ptmr_r[g] - 1'b1;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Transmit choice: resend has the slot, otherwise next new unit
   logic [SRARQ_SEQ_W-1:0] next_seq_r;
   logic [SRARQ_SEQ_W-1:0] next_seq_nxt;
   logic use_new;
   assign use_new = tx_opportunity_i && !any_rdy;
   assign next_seq_nxt = tx_sent_i ? tx_sent_seq_i + 1'b1 : next_seq_r;

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         next_seq_r <= '0;
         tx_resend_o <= 1'b0;
         tx_new_o <= 1'b0;
         tx_seq_o <= '0;
         drop_o <= 1'b0;
         drop_seq_o <= '0;
      end else begin
         next_seq_r <= next_seq_nxt;
         tx_resend_o <= tx_opportunity_i && any_rdy;
         tx_new_o <= use_new;
         tx_seq_o <= any_rdy ? pseq_r[rdy_idx] : next_seq_r;
         drop_o <= any_drop;
         drop_seq_o <= any_drop ? pseq_r[drop_idx] : drop_seq_o;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error count drives the modulation step; counter restarts after each step
   logic [SRARQ_ERR_W-1:0] err_cnt_r;
   logic [SRARQ_MOD_W-1:0] mod_r;
   logic mod_chg_r;
   logic err_over;
   assign err_over = nack_in && (err_cnt_r >= err_limit_i);

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         err_cnt_r <= SRARQ_ERR_RESET;
         mod_r <= SRARQ_MOD_RESET;
         mod_chg_r <= 1'b0;
      end else begin
         mod_chg_r <= err_over;
         if (err_over) begin
            err_cnt_r <= SRARQ_ERR_RESET;
            mod_r <= mod_r + 1'b1;
         end else if (nack_in) begin
            err_cnt_r <= err_cnt_r + 1'b1;
         end
      end
   end
   assign mod_class_o = mod_r;
   assign mod_change_o = mod_chg_r;

   logic unused_ok;
   assign unused_ok = ack_in ^ (|rx_pru_i);
endmodule

// ===== test/srarq_peer_model.sv
// Purpose: Peer station returning acknowledgement fields
// Assumes: Bench requests one field per cycle
// Notes: Between fields the lines toggle, so stale values are never trusted
`timescale 1ns/10ps
module srarq_peer_model
   import srarq_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Bench request
   input wire logic cmd_i,
   input wire logic cmd_nack_i,
   input wire logic [SRARQ_SEQ_W-1:0] cmd_seq_i,
   // Field toward the block
   output logic peer_ack_valid_o,
   output logic peer_nack_o,
   output logic [SRARQ_SEQ_W-1:0] peer_ack_seq_o
);
////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         peer_ack_valid_o <= 1'b0;
         peer_nack_o <= 1'b0;
         peer_ack_seq_o <= 8'h00;
      end else if (cmd_i) begin
         peer_ack_valid_o <= 1'b1;
         peer_nack_o <= cmd_nack_i;
         peer_ack_seq_o <= cmd_seq_i;
      end else begin
         peer_ack_valid_o <= 1'b0;
         peer_nack_o <= ~peer_nack_o;
         peer_ack_seq_o <= ~peer_ack_seq_o;
      end
   end
endmodule

// ===== test/srarq_tb_top.sv
// Purpose: Self-checking bench for the retransmission block
// Assumes: Full 187500-cycle delays, so the run spans one delay
// Notes: Receive and transmit traffic overlap to keep the run short
`timescale 1ns/10ps
module srarq_tb_top;
   import srarq_pkg::*;
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic rx_v = 1'b0, rx_ok = 1'b0, sent = 1'b0, opp = 1'b0, cmd = 1'b0, cmd_nack = 1'b0;
   logic [7:0] rx_seq = 8'h00, sent_seq = 8'h00, cmd_seq = 8'h00, aseq, tseq, dseq, ps;
   logic [3:0] rx_user = 4'h0;
   logic [5:0] rx_pru = 6'h00;
   logic pv, pn, av, an, rs, nw, drp, mc, ovf;
   logic [1:0] mcls;
   logic [31:0] cyc = 32'h0, rng = 32'h09C0;
   logic [40:0] exp_q[$];
   int fail_count = 0;
   int num_checks = 0;
////////////////////////////////////////////////////////////
   always #20 ref_clk_i = ~ref_clk_i;
   srarq_peer_model i_srarq_peer_model (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .cmd_i(cmd), .cmd_nack_i(cmd_nack), .cmd_seq_i(cmd_seq), .peer_ack_valid_o(pv),
      .peer_nack_o(pn), .peer_ack_seq_o(ps));
   srarq_top i_srarq_top (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .rx_unit_valid_i(rx_v),
      .rx_crc_ok_i(rx_ok), .rx_seq_i(rx_seq), .rx_user_i(rx_user), .rx_pru_i(rx_pru),
      .own_user_i(4'h3), .ack_valid_o(av), .ack_nack_o(an), .ack_seq_o(aseq),
      .ack_overflow_o(ovf), .tx_sent_i(sent), .tx_sent_seq_i(sent_seq), .peer_ack_valid_i(pv),
      .peer_nack_i(pn), .peer_ack_seq_i(ps), .tx_opportunity_i(opp), .retry_limit_i(4'h1),
      .err_limit_i(8'h02), .tx_resend_o(rs), .tx_new_o(nw), .tx_seq_o(tseq), .drop_o(drp),
      .drop_seq_o(dseq), .mod_class_o(mcls), .mod_change_o(mc));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic chk(input logic [40:0] got, input logic [40:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic print_verdict();
      if (fail_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic peer(input logic nk, input logic [7:0] sq);
      cmd = 1'b1;
      cmd_nack = nk;
      cmd_seq = sq;
      @(negedge ref_clk_i);
      cmd = 1'b0;
      // An idle cycle between fields keeps each strobe a clean pulse
      @(negedge ref_clk_i);
   endtask
   task automatic opp_chk(input logic rs_e, input logic [7:0] sq);
      int n;
      n = 0;
      opp = 1'b1;
      @(negedge ref_clk_i);
      opp = 1'b0;
      while (rs !== 1'b1 && nw !== 1'b1 && n < 3) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk({rs, nw, tseq}, {rs_e, ~rs_e, sq});
      sent = nw;
      sent_seq = sq;
      @(negedge ref_clk_i);
      sent = 1'b0;
   endtask
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 32'h1;
      if (cyc == 32'h00030D40) begin
         fail_count++;
         print_verdict();
      end
   end
   // Every ack must match the oldest pending verdict at its exact cycle
   always @(negedge ref_clk_i) begin
      if (av === 1'b1) begin
         chk({an, aseq, cyc}, exp_q.pop_front());
      end
   end
   initial begin
      repeat (20) @(negedge ref_clk_i);
      chk({av, rs, nw, drp, mc, mcls}, 41'h0);
      reset_n_i = 1'b1;
      sent = 1'b1;
      sent_seq = 8'h20;
      rx_v = 1'b1;
      // Nine own units: the ninth finds all eight verdict slots busy
      for (int i = 0; i < 10; i++) begin
         rng = xs(rng);
         rx_ok = (i < 2) ? i[0] : rng[0];
         rx_seq = rng[15:8];
         rx_pru = rng[21:16];
         rx_user = (i == 4) ? 4'h5 : 4'h3;
         if (i != 4 && i != 9) exp_q.push_back({~rx_ok, rx_seq, cyc + 32'h1 + SRARQ_ACK_DELAY_CYC});
         @(negedge ref_clk_i);
         sent = 1'b0;
         chk(ovf, i == 9);
      end
      rx_v = 1'b0;
      opp_chk(1'b0, 8'h21);
      peer(1'b1, 8'h05);
      peer(1'b1, 8'h06);
      repeat (SRARQ_RESEND_DELAY_CYC + 2) @(negedge ref_clk_i);
      opp_chk(1'b1, 8'h05);
      opp_chk(1'b1, 8'h06);
      opp_chk(1'b0, 8'h22);
      peer(1'b0, 8'h06);
      peer(1'b1, 8'h05);
      for (int n = 0; n < 4 && drp !== 1'b1; n++) @(negedge ref_clk_i);
      chk({drp, dseq, mc}, {1'b1, 8'h05, 1'b1});
      opp_chk(1'b0, 8'h23);
      chk(mcls, 2'h1);
      chk(exp_q.size(), 0);
      print_verdict();
   end
endmodule

// ===== test/srarq_top_assertions.sv
// Purpose: Port checks for the retransmission block
// Assumes: One clock, synchronous active-low reset
// Notes: The 7.5 ms delays exceed delay ranges, so an uptime counter bounds them
`timescale 1ns/10ps
module srarq_top_assertions
   import srarq_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Watched ports
   input wire logic ack_valid_o,
   input wire logic tx_opportunity_i,
   input wire logic tx_resend_o,
   input wire logic tx_new_o,
   input wire logic peer_ack_valid_i,
   input wire logic peer_nack_i,
   input wire logic drop_o,
   input wire logic [SRARQ_MOD_W-1:0] mod_class_o,
   input wire logic mod_change_o
);
////////////////////////////////////////////////////////////
   logic [23:0] up_r;
   wire nack_in = peer_ack_valid_i && peer_nack_i;
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         up_r <= 24'h000000;
      end else if (up_r != 24'hFFFFFF) begin
         up_r <= up_r + 24'h000001;
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   a_ack_not_early: assert property (ack_valid_o |-> up_r >= SRARQ_ACK_DELAY_CYC)
      else $error("ack before its delay");
   a_resend_not_early: assert property (tx_resend_o |-> up_r >= SRARQ_RESEND_DELAY_CYC)
      else $error("resend before its delay");
   a_opp_served: assert property (tx_opportunity_i |=> ##[0:1] (tx_resend_o || tx_new_o))
      else $error("send slot left unused");
   a_one_kind: assert property (!(tx_resend_o && tx_new_o))
      else $error("resend and new together");
   a_send_cause: assert property ((tx_resend_o || tx_new_o) |->
      ($past(tx_opportunity_i) || $past(tx_opportunity_i, 2)))
      else $error("send without slot");
   a_drop_cause: assert property (drop_o |-> ($past(nack_in) || $past(nack_in, 2)))
      else $error("drop without nack");
   a_mod_step: assert property ($changed(mod_class_o) |->
      mod_class_o == $past(mod_class_o) + 2'h1)
      else $error("modulation class jumped");
   a_mod_cause: assert property ($changed(mod_class_o) |->
      ($past(nack_in) || $past(nack_in, 2)))
      else $error("class change without nack");
   c_resend: cover property (tx_resend_o);
   c_drop: cover property (drop_o);
   c_mod: cover property (mod_change_o);
endmodule
bind srarq_top srarq_top_assertions i_srarq_top_assertions (
   .ref_clk_i(ref_clk_i),
   .reset_n_i(reset_n_i),
   .ack_valid_o(ack_valid_o),
   .tx_opportunity_i(tx_opportunity_i),
   .tx_resend_o(tx_resend_o),
   .tx_new_o(tx_new_o),
   .peer_ack_valid_i(peer_ack_valid_i),
   .peer_nack_i(peer_nack_i),
   .drop_o(drop_o),
   .mod_class_o(mod_class_o),
   .mod_change_o(mod_change_o)
);
